// *** hw/i2c_status_flags.sv ***
/*
  Target-side two-wire controller slice that keeps the bus status flags:
  last condition seen, transfer direction, receive and transmit buffer
  full. Includes the register port, the buffers and a masked interrupt.
  Assumes the bus lines are asynchronous open-drain inputs and that the
  register port master follows the single-cycle strobe protocol.
*/
// Function
// - Stop detected sets stop-seen flag, bit 4 of bus_status.
// - Start or repeated start clears stop-seen flag.
// - Start or repeated start sets start-seen flag, bit 3.
// - Stop detected clears start-seen flag.
// - Direction flag bit 2: 1 means target sends, 0 means target receives.
// - Direction flag updates only from the read/write bit of an address byte.
// - Receive-full flag bit 1 sets when a received byte enters receive buffer.
// - Software read of receive buffer clears receive-full flag.
// - Software write of transmit buffer sets transmit-full flag, bit 0.
// - Finished transmission of the buffered byte clears transmit-full flag.
`timescale 1ns/1ps

module i2c_status_flags (
  input  wire logic                            clock_i,
  input  wire logic                            rstn_i,
  input  wire logic [i2c_status_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [i2c_status_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                            wr_i,
  input  wire logic                            rd_i,
  output logic      [i2c_status_pkg::DATA_W-1:0] rdata_o,
  output logic                                 irq_o,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o
);
  import i2c_status_pkg::*;

  bus_event_if ev ();

  target_state_t        state_reg;
  target_state_t        state_next;
  logic                 start_seen_reg;
  logic                 stop_seen_reg;
  logic                 direction_reg;
  logic                 rx_full_reg;
  logic                 tx_full_reg;
  logic [7:0]           rx_buffer_reg;
  logic [7:0]           tx_buffer_reg;
  logic [7:0]           control_reg;
  logic [EV_W-1:0]      irq_status_reg;
  logic [EV_W-1:0]      irq_mask_reg;
  logic                 ack_req_reg;
  logic                 sda_low_reg;
  logic                 sda_low_next;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;
  logic [7:0]           shift_byte;
  logic [3:0]           bit_cnt;
  // Declared early: the shifter instance reads it
  logic                 tx_load;

  bus_condition_detect u_detect (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ev      (ev.source)
  );

  // Address byte data is shifted here too; loads only happen in send frames
  byte_shifter #(
    .BYTE_W (8)
  ) u_shift (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ev          (ev.sink),
    .load_i      (tx_load),
    .load_data_i (tx_buffer_reg),
    .byte_o      (shift_byte),
    .bit_cnt_o   (bit_cnt)
  );

  // Register port decode
  wire wr_status  = wr_i & (addr_i == OFS_BUS_STATUS);
  wire wr_txbuf   = wr_i & (addr_i == OFS_TX_BUFFER);
  wire wr_control = wr_i & (addr_i == OFS_CONTROL);
  wire wr_mask    = wr_i & (addr_i == OFS_IRQ_MASK);
  wire rd_rxbuf   = rd_i & (addr_i == OFS_RX_BUFFER);
  wire rd_irq     = rd_i & (addr_i == OFS_IRQ_STATUS);

  wire       enabled   = control_reg[CTRL_ENABLE_BIT];
  wire [6:0] own_addr  = control_reg[CTRL_ADDR_MSB:CTRL_ADDR_LSB];

  // Byte framing on the bus
  wire byte_done  = ev.scl_rise & (bit_cnt == CNT_LAST_DATA);
  wire ack_rise   = ev.scl_rise & (bit_cnt == CNT_ACK);
  wire [7:0] got_byte = {shift_byte[6:0], ev.sda};
  wire addr_match = enabled & (got_byte[7:1] == own_addr);

  wire addr_done = byte_done & (state_reg == ST_ADDR);
  wire rx_done   = byte_done & (state_reg == ST_RX);
  wire tx_done   = byte_done & (state_reg == ST_TX);
  assign tx_load = ev.scl_fall & (state_reg == ST_TX) & (bit_cnt == RST_BITCNT);

  // Target state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   state_next = ST_IDLE;
      ST_ADDR: begin
        if (addr_done) begin
          if (!addr_match) begin
            state_next = ST_IGNORE;
          end else if (got_byte[0]) begin
            state_next = ST_TX;
          end else begin
            state_next = ST_RX;
          end
        end
      end
      ST_RX:     state_next = ST_RX;
      // Controller not acknowledging ends the send phase
      ST_TX: begin
        if (ack_rise & ev.sda) begin
          state_next = ST_IGNORE;
        end
      end
      ST_IGNORE: state_next = ST_IGNORE;
      default:   state_next = ST_IDLE;
    endcase
    if (ev.start) begin
      state_next = ST_ADDR;
    end else if (ev.stop) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Last bus condition flags
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      start_seen_reg <= RST_FLAGS[START_SEEN_BIT];
      stop_seen_reg  <= RST_FLAGS[STOP_SEEN_BIT];
    end else if (ev.start) begin
      start_seen_reg <= 1'b1;
      stop_seen_reg  <= 1'b0;
    end else if (ev.stop) begin
      stop_seen_reg  <= 1'b1;
      start_seen_reg <= 1'b0;
    end
  end

  // Direction from the address byte only
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      direction_reg <= RST_FLAGS[DIRECTION_BIT];
    end else if (addr_done & addr_match) begin
      direction_reg <= got_byte[0];
    end
  end

  // Receive buffer and its full flag; a new byte wins over a read
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rx_buffer_reg <= RST_BYTE;
      rx_full_reg   <= RST_FLAGS[RECEIVE_FULL_BIT];
    end else if (rx_done) begin
      rx_buffer_reg <= got_byte;
      rx_full_reg   <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full_reg   <= 1'b0;
    end
  end

  // Transmit buffer and its full flag; a software write wins
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_buffer_reg <= RST_BYTE;
      tx_full_reg   <= RST_FLAGS[TRANSMIT_FULL_BIT];
    end else if (wr_txbuf) begin
      tx_buffer_reg <= wdata_i[7:0];
      tx_full_reg   <= 1'b1;
    end else if (tx_done) begin
      tx_full_reg   <= 1'b0;
    end
  end

  // Control and mask; status writes are dropped
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      control_reg  <= RST_CONTROL;
      irq_mask_reg <= RST_EVENTS;
    end else begin
      if (wr_control) begin
        control_reg <= wdata_i[7:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= wdata_i[EV_W-1:0];
      end
    end
  end

  // Sticky events, cleared by a read; a new event survives the read
  wire [EV_W-1:0] events = {tx_done, rx_done, ev.stop, ev.start};

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      irq_status_reg <= RST_EVENTS;
    end else begin
      irq_status_reg <= (rd_irq ? RST_EVENTS : irq_status_reg) | events;
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // Acknowledge and data drive; changes only while the clock line is low
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_req_reg <= 1'b0;
    end else if (ev.start | ev.stop) begin
      ack_req_reg <= 1'b0;
    end else if ((addr_done & addr_match) | rx_done) begin
      ack_req_reg <= 1'b1;
    end else if (ev.scl_fall) begin
      ack_req_reg <= 1'b0;
    end
  end

  always_comb begin
    sda_low_next = sda_low_reg;
    if (ev.start | ev.stop) begin
      sda_low_next = 1'b0;
    end else if (ev.scl_fall) begin
      if (ack_req_reg & (bit_cnt == CNT_ACK)) begin
        sda_low_next = 1'b1;
      end else if ((state_reg == ST_TX) & (bit_cnt == RST_BITCNT)) begin
        sda_low_next = ~tx_buffer_reg[7];
      end else if ((state_reg == ST_TX) & (bit_cnt < CNT_ACK)) begin
        sda_low_next = ~shift_byte[7];
      end else begin
        sda_low_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sda_low_reg <= 1'b0;
    end else begin
      sda_low_reg <= sda_low_next;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low_reg;

  // Read data, valid the cycle after the strobe only
  wire [DATA_W-1:0] status_word = {11'h000, stop_seen_reg, start_seen_reg,
                                   direction_reg, rx_full_reg, tx_full_reg};

  always_comb begin
    rdata_next = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_BUS_STATUS: rdata_next = status_word;
        OFS_RX_BUFFER:  rdata_next = {8'h00, rx_buffer_reg};
        OFS_TX_BUFFER:  rdata_next = {8'h00, tx_buffer_reg};
        OFS_CONTROL:    rdata_next = {8'h00, control_reg};
        OFS_IRQ_STATUS: rdata_next = {12'h000, irq_status_reg};
        OFS_IRQ_MASK:   rdata_next = {12'h000, irq_mask_reg};
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

endmodule : i2c_status_flags

// *** hw/i2c_status_pkg.sv ***
/*
  Constants shared by the two-wire status-flag block: register map,
  flag positions, event bits, control fields, reset values and states.
  Assumes a 16-bit register port with a 4-bit word address.
*/
package i2c_status_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register map, word addresses on the plain register port
  localparam logic [3:0] OFS_BUS_STATUS = 4'h0;
  localparam logic [3:0] OFS_RX_BUFFER  = 4'h1;
  localparam logic [3:0] OFS_TX_BUFFER  = 4'h2;
  localparam logic [3:0] OFS_CONTROL    = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'h5;

  // Flag positions in bus_status
  localparam int STOP_SEEN_BIT      = 4;
  localparam int START_SEEN_BIT     = 3;
  localparam int DIRECTION_BIT      = 2;
  localparam int RECEIVE_FULL_BIT   = 1;
  localparam int TRANSMIT_FULL_BIT  = 0;

  // Event bits in irq status and mask
  localparam int EV_W         = 4;
  localparam int EV_START_BIT = 0;
  localparam int EV_STOP_BIT  = 1;
  localparam int EV_RX_BIT    = 2;
  localparam int EV_TX_BIT    = 3;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ADDR_LSB   = 1;
  localparam int CTRL_ADDR_MSB   = 7;

  // Reset values
  localparam logic [4:0]  RST_FLAGS   = 5'h00;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [3:0]  RST_EVENTS  = 4'h0;
  localparam logic [3:0]  RST_BITCNT  = 4'h0;

  // Bit counter landmarks within one byte frame
  localparam logic [3:0]  CNT_LAST_DATA = 4'h7;
  localparam logic [3:0]  CNT_ACK       = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RX     = 3'b010,
    ST_TX     = 3'b011,
    ST_IGNORE = 3'b100
  } target_state_t;

endpackage : i2c_status_pkg

// *** hw/bus_event_if.sv ***
/*
  Carrier for synchronised bus events between the condition detector
  and its consumers. All signals are one-cycle pulses on clock_i except
  sda, which is the synchronised data line level.
*/
`timescale 1ns/1ps

interface bus_event_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic sda;

  modport source (output start, output stop, output scl_rise, output scl_fall, output sda);
  modport sink   (input start, input stop, input scl_rise, input scl_fall, input sda);
endinterface : bus_event_if

// *** hw/bus_condition_detect.sv ***
/*
  Synchronises the clock and data lines and finds the clock line edges and the
  start and stop conditions. Assumes both lines arrive asynchronously
  and are far slower than clock_i.
*/
`timescale 1ns/1ps

module bus_condition_detect (
  input  wire logic   clock_i,
  input  wire logic   rstn_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  bus_event_if.source ev
);
  import i2c_status_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  // Lines idle high, so reset to high to avoid a false edge
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  wire scl_high = scl_sync_reg[1] & scl_prev_reg;

  assign ev.sda      = sda_sync_reg[1];
  assign ev.scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  assign ev.scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  assign ev.start    = scl_high & sda_prev_reg & ~sda_sync_reg[1];
  assign ev.stop     = scl_high & ~sda_prev_reg & sda_sync_reg[1];

endmodule : bus_condition_detect

// *** hw/byte_shifter.sv ***
/*
  Byte shift register and bit counter for one bus frame: eight data
  clocks then one acknowledge clock. Assumes events from the detector.
*/
`timescale 1ns/1ps

module byte_shifter #(
  parameter int BYTE_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  bus_event_if.sink              ev,
  input  wire logic              load_i,
  input  wire logic [BYTE_W-1:0] load_data_i,
  output logic      [BYTE_W-1:0] byte_o,
  output logic      [3:0]        bit_cnt_o
);
  import i2c_status_pkg::*;

  logic [BYTE_W-1:0] shift_reg;
  logic [3:0]        cnt_reg;

  wire in_data = (cnt_reg < CNT_ACK);

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      shift_reg <= '0;
      cnt_reg   <= RST_BITCNT;
    end else if (ev.start) begin
      cnt_reg <= RST_BITCNT;
    end else if (load_i) begin
      shift_reg <= load_data_i;
    end else if (ev.scl_rise) begin
      if (in_data) begin
        shift_reg <= {shift_reg[BYTE_W-2:0], ev.sda};
        cnt_reg   <= cnt_reg + 4'h1;
      end else begin
        cnt_reg <= RST_BITCNT;
      end
    end
  end

  assign byte_o    = shift_reg;
  assign bit_cnt_o = cnt_reg;

endmodule : byte_shifter

// *** verif/bus_ctrl_model.sv ***
/*
  Remote two-wire controller model: start, stop and nine-clock transfers.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps

module bus_ctrl_model (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Long release before clock rise: target ack may still hold the line
  task automatic start_cond();
    #13;
    #100 sda_low_o = 1'b0;
    #200 scl_o = 1'b1;
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #13;
    #100 sda_low_o = 1'b1;
    #200 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #200;
  endtask : stop_cond

  // Eight bits then ack, MSB first; a 1 releases the line
  task automatic xfer(input logic [8:0] v, output logic [8:0] seen);
    #13;
    for (int i = 8; i >= 0; i--) begin
      #100 sda_low_o = !v[i];
      #200 scl_o = 1'b1;
      seen[i] = sda_i;
      #100 scl_o = 1'b0;
    end
  endtask : xfer
endmodule : bus_ctrl_model

// *** verif/i2c_status_flags_asserts.sv ***
/*
  Port-level checker for the status-flag block, bound below.
  Assumes bus lines change away from clock_i edges.
*/
`timescale 1ns/1ps

module i2c_status_flags_asserts
  import i2c_status_pkg::*;
(
  input wire logic                                clock_i,
  input wire logic                                rstn_i,
  input wire logic [i2c_status_pkg::ADDR_W-1:0]  addr_i,
  input wire logic [i2c_status_pkg::DATA_W-1:0]  wdata_i,
  input wire logic                                wr_i,
  input wire logic                                rd_i,
  input wire logic [i2c_status_pkg::DATA_W-1:0]  rdata_o,
  input wire logic                                irq_o,
  input wire logic                                scl_i,
  input wire logic                                sda_i,
  input wire logic                                sda_o,
  input wire logic                                sda_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  logic       scl_q;
  logic       sda_q;
  logic       last_stop;
  logic       seen;
  logic [3:0] age;
  wire        start_ev = scl_q && scl_i && sda_q && !sda_i;
  wire        stop_ev  = scl_q && scl_i && !sda_q && sda_i;
  wire        rd_st    = rd_i && addr_i == OFS_BUS_STATUS;

  // Age saturates so a stale condition stays checkable
  always_ff @(posedge clock_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (!rstn_i) begin
      seen <= 1'b0;
      age <= 4'h0;
      last_stop <= 1'b0;
    end else if (start_ev || stop_ev) begin
      seen <= 1'b1;
      age <= 4'h0;
      last_stop <= stop_ev;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end

  stop_flag_a:
  assert property (rd_st && seen && last_stop && age > 4'h6 |=> rdata_o[4:3] == 2'b10)
    else $error("stop flag wrong after stop");
  start_flag_a:
  assert property (rd_st && seen && !last_stop && age > 4'h6 |=> rdata_o[4:3] == 2'b01)
    else $error("start flag wrong after start");
  rx_clear_a:
  assert property (rd_i && addr_i == OFS_RX_BUFFER ##[1:4] rd_st |=> !rdata_o[1])
    else $error("receive full not cleared by read");
  tx_set_a:
  assert property (wr_i && addr_i == OFS_TX_BUFFER ##[1:4] rd_st |=> rdata_o[0])
    else $error("transmit full not set by write");
  status_ro_a:
  assert property (rd_st ##1 (wr_i && addr_i == OFS_BUS_STATUS) ##1 rd_st
    |=> rdata_o == $past(rdata_o, 2)) else $error("status changed by write");
  rdata_idle_a:
  assert property (!rd_i |=> rdata_o == 16'h0000) else $error("read data without read");
  upper_zero_a:
  assert property (rd_st |=> rdata_o[15:5] == 11'h000) else $error("status upper bits set");
  irq_mask_a:
  assert property (wr_i && addr_i == OFS_IRQ_MASK && wdata_i[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt with all masked");
  irq_clear_a:
  assert property (rd_i && addr_i == OFS_IRQ_STATUS |=> !irq_o)
    else $error("interrupt after status read");
  sda_level_a:
  assert property (sda_o == 1'b0) else $error("data output not held low");
  sda_change_a:
  assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data drive changed with clock high");

  cover property (rd_st && seen && last_stop && age > 4'h6);
  cover property (rd_st && seen && !last_stop && age > 4'h6);
  cover property (irq_o);
endmodule : i2c_status_flags_asserts

bind i2c_status_flags i2c_status_flags_asserts i2c_status_flags_asserts_inst (
  .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// *** verif/tb_i2c_status_flags.sv ***
/*
  Bench for the status-flag block: register tasks, bus model, checks.
  Assumes the model and the bound checker are compiled first.
*/
`timescale 1ns/1ps

module tb_i2c_status_flags;
  import i2c_status_pkg::*;
  logic        clock_i;
  logic        rstn_i;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic        irq_o;
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe_o;
  wire         sda_line;
  logic [8:0]  got;
  int          n_mismatch;
  int          cmp_count;

  // Open drain with pull-up
  assign sda_line = !(sda_low || (sda_oe_o && !sda_o));

  i2c_status_flags i2c_status_flags_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

  bus_ctrl_model bus_ctrl_model_inst (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; caller releases the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
  endtask : bus

  task automatic idle();
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : idle

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    idle();
    @(negedge clock_i);
    chk(rdata_o, exp);
    @(posedge clock_i);
  endtask : rchk

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
    idle();
    @(posedge clock_i);
  endtask : wreg

  task automatic ichk(input logic exp);
    @(negedge clock_i);
    chk({15'h0000, irq_o}, {15'h0000, exp});
    @(posedge clock_i);
  endtask : ichk

  task automatic settle();
    repeat (6) @(posedge clock_i);
  endtask : settle

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Whole run is some 26 us
  initial begin
    #200us;
    n_mismatch++;
    conclude();
  end

  initial begin
    rstn_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    ichk(1'b0);
    rchk(OFS_BUS_STATUS, 16'h0000);
    rchk(4'hF, 16'h0000);
    wreg(OFS_CONTROL, 16'h00B5);
    wreg(OFS_IRQ_MASK, 16'h000F);
    rchk(OFS_CONTROL, 16'h00B5);
    rchk(OFS_IRQ_MASK, 16'h000F);
    $display("test reset done");
    bus_ctrl_model_inst.start_cond();
    settle();
    rchk(OFS_BUS_STATUS, 16'h0008);
    ichk(1'b1);
    rchk(OFS_IRQ_STATUS, 16'h0001);
    ichk(1'b0);
    $display("test start done");
    bus_ctrl_model_inst.xfer(9'h169, got);
    chk({15'h0000, got[0]}, 16'h0000);
    bus_ctrl_model_inst.xfer(9'h14B, got);
    settle();
    rchk(OFS_BUS_STATUS, 16'h000A);
    rchk(OFS_RX_BUFFER, 16'h00A5);
    rchk(OFS_BUS_STATUS, 16'h0008);
    rchk(OFS_IRQ_STATUS, 16'h0004);
    bus(1'b0, OFS_BUS_STATUS, 16'h0000);
    bus(1'b1, OFS_BUS_STATUS, 16'hFFFF);
    bus(1'b0, OFS_BUS_STATUS, 16'h0000);
    idle();
    @(posedge clock_i);
    rchk(OFS_BUS_STATUS, 16'h0008);
    $display("test receive done");
    wreg(OFS_TX_BUFFER, 16'h003C);
    rchk(OFS_BUS_STATUS, 16'h0009);
    rchk(OFS_TX_BUFFER, 16'h003C);
    bus_ctrl_model_inst.start_cond();
    bus_ctrl_model_inst.xfer(9'h16B, got);
    chk({15'h0000, got[0]}, 16'h0000);
    settle();
    rchk(OFS_BUS_STATUS, 16'h000D);
    bus_ctrl_model_inst.xfer(9'h1FF, got);
    chk({8'h00, got[8:1]}, 16'h003C);
    settle();
    rchk(OFS_BUS_STATUS, 16'h000C);
    rchk(OFS_IRQ_STATUS, 16'h0009);
    bus_ctrl_model_inst.stop_cond();
    settle();
    rchk(OFS_BUS_STATUS, 16'h0014);
    $display("test send done");
    wreg(OFS_IRQ_MASK, 16'h0000);
    bus_ctrl_model_inst.start_cond();
    bus_ctrl_model_inst.xfer(9'h045, got);
    chk({15'h0000, got[0]}, 16'h0001);
    settle();
    ichk(1'b0);
    rchk(OFS_BUS_STATUS, 16'h000C);
    bus_ctrl_model_inst.stop_cond();
    settle();
    rchk(OFS_BUS_STATUS, 16'h0014);
    rchk(OFS_IRQ_STATUS, 16'h0003);
    $display("test mismatch done");
    conclude();
  end
endmodule : tb_i2c_status_flags
